// *** core/bgp_pkg.sv ***
// Package with register map, field layout and reset values for the byte-wide port
package bgp_pkg;
  // ************************************************************
  // Register map and fields
  // ************************************************************
  localparam logic [7:0] BGP_ADDR_CONTROL = 8'h24;
  localparam logic [7:0] BGP_ADDR_DATA = 8'h40;
  localparam logic [7:0] BGP_ADDR_DIRECTION = 8'h47;
  localparam logic [7:0] BGP_DIR_RESET = 8'hc0;
  localparam logic [7:0] BGP_LATCH_RESET = 8'h00;
  localparam logic [7:0] BGP_CTRL_RESET = 8'h00;
  localparam int BGP_FETCH_BIT = 7;
  localparam int BGP_BOOT_HI = 6;
  localparam int BGP_BOOT_LO = 5;
  localparam int BGP_CSSEL_BIT = 4;
  localparam int BGP_MODE_HI = 3;
  localparam int BGP_MODE_LO = 2;
  localparam int BGP_ILVL_HI = 1;
  localparam int BGP_ILVL_LO = 0;
  localparam logic [1:0] BGP_MODE_IN = 2'h0;
  localparam logic [1:0] BGP_MODE_OUT = 2'h1;
  localparam logic [1:0] BGP_MODE_SLAVE = 2'h2;
  localparam logic [1:0] BGP_MODE_EXTIO = 2'h3;
  localparam logic [7:0] BGP_CTRL_WMASK = 8'h9f;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bgp_bus_s;

  typedef struct packed {
    logic slaveReadN;
    logic slaveWriteN;
    logic slaveAddrHi;
    logic slaveAddrLo;
    logic chipSelectN;
  } bgp_slave_s;
endpackage

// *** core/bgp_pin_cell.sv ***
// One pin's ownership multiplexer: serial clock, then peripheral, then port
module bgp_pin_cell
  import bgp_pkg::*;
(
  input wire logic serClkSel, // Serial output clock owns the pin
  input wire logic serClkVal, // Serial clock level
  input wire logic perSel, // Peripheral owns the pin
  input wire logic perOe, // Peripheral drives the pin
  input wire logic perVal, // Peripheral level
  input wire logic portDir, // Port direction bit
  input wire logic portVal, // Port latch bit
  output logic pinOe, // Resulting enable
  output logic pinVal // Resulting level
);
  // Fixed priority keeps serial clock above every other owner
  always_comb begin
    if (serClkSel) begin
      pinOe = 1'b1;
      pinVal = serClkVal;
    end else if (perSel) begin
      pinOe = perOe;
      pinVal = perVal;
    end else begin
      pinOe = portDir;
      pinVal = portVal;
    end
  end
endmodule

// *** core/bgp_port.sv ***
// Byte-wide general purpose port with slave port and external bus pin sharing
module bgp_port
  import bgp_pkg::*;
#(
  parameter int WIDTH = 8 // Pin count
)
(
  input wire logic core_clk, // Peripheral clock
  input wire logic rst, // Synchronous reset, high
  input wire logic clkEn, // Clock enable, freezes state when low
  input wire bgp_bus_s bus, // Register access request
  output logic [7:0] rdata, // Registered read data
  input wire logic [WIDTH-1:0] pinIn, // Pin levels
  output logic [WIDTH-1:0] pinOut, // Pin drive levels
  output logic [WIDTH-1:0] pinOe, // Pin output enables, high drives
  input wire logic [1:0] boot_mode_pins, // Boot mode strap levels
  input wire logic parallelBoot, // Parallel bootstrap has picked slave port
  input wire logic attention_out_n, // Slave attention level from slave port
  input wire logic other_port_pin_seven, // Chip select from another port
  input wire logic [5:0] extIoAddr, // External bus address from bus unit
  input wire logic [1:0] serClkOutSel, // Serial output clock selects, bit1 first port
  input wire logic [1:0] serClkOut, // Serial clock levels, bit1 first port
  output bgp_slave_s slaveSig, // Strobes and address to slave port
  output logic [1:0] serClkIn, // Pin one and zero levels for serial clocks
  output logic extIoEnable, // External bus enabled
  output logic slaveEnable, // Slave port active
  output logic [1:0] slaveIrqLevel, // Slave interrupt priority, zero is off
  output logic fetchIgnore // Ignore boot pins for program fetch
);
  // ************************************************************
  // Register state
  // ************************************************************
  logic [WIDTH-1:0] dir_reg, dir_next;
  logic [WIDTH-1:0] hold_reg, hold_next;
  logic holdPend_reg, holdPend_next;
  logic [WIDTH-1:0] latch_reg, latch_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [WIDTH-1:0] oe_reg, oe_next;
  logic [WIDTH-1:0] out_reg, out_next;
  bgp_slave_s slv_reg, slv_next;
  logic [1:0] ser_reg, ser_next;
  logic [3:0] flags_reg, flags_next;
  logic [WIDTH-1:0] cellOe, cellVal;
  logic [WIDTH-1:0] perSel, perOe, perVal, serSel, serVal;
  logic slaveOn, extOn;

  // Mode decode; the boot strap also switches the slave pins on
  always_comb begin
    extOn = ctrl_reg[BGP_MODE_HI:BGP_MODE_LO] == BGP_MODE_EXTIO;
    slaveOn = (ctrl_reg[BGP_MODE_HI:BGP_MODE_LO] == BGP_MODE_SLAVE) || parallelBoot;
  end

  // Register writes; data goes to the holding buffer first
  always_comb begin
    dir_next = dir_reg;
    hold_next = hold_reg;
    holdPend_next = 1'b0;
    latch_next = latch_reg;
    ctrl_next = ctrl_reg;
    if (holdPend_reg) begin
      latch_next = hold_reg;
    end
    if (bus.wr) begin
      unique case (bus.addr)
        BGP_ADDR_DIRECTION: dir_next = bus.wdata[WIDTH-1:0];
        BGP_ADDR_DATA: begin
          hold_next = bus.wdata[WIDTH-1:0];
          holdPend_next = 1'b1;
        end
        BGP_ADDR_CONTROL: ctrl_next = bus.wdata & BGP_CTRL_WMASK;
        default: ;
      endcase
    end
  end

  // Read path: direction is write-only and reads as zero
  always_comb begin
    rdata_next = rdata_reg;
    if (bus.rd) begin
      unique case (bus.addr)
        BGP_ADDR_DATA: rdata_next = pinIn;
        BGP_ADDR_CONTROL: begin
          rdata_next = ctrl_reg;
          rdata_next[BGP_BOOT_HI:BGP_BOOT_LO] = boot_mode_pins;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Per-pin peripheral claims; slave strobes and address are inputs
  always_comb begin
    perSel = '0;
    perOe = '0;
    perVal = '0;
    serSel = '0;
    serVal = '0;
    if (extOn) begin
      perSel[7:2] = 6'h3f;
      perOe[7:2] = 6'h3f;
      perVal[7:2] = extIoAddr;
    end else if (slaveOn) begin
      perSel[7] = 1'b1;
      perOe[7] = 1'b1;
      perVal[7] = attention_out_n;
      perSel[5:2] = 4'hf;
      perSel[6] = ctrl_reg[BGP_CSSEL_BIT];
    end
    serSel[1:0] = serClkOutSel;
    serVal[1:0] = serClkOut;
  end

  // Pin ownership, one cell per pin
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    bgp_pin_cell u_cell (
      .serClkSel(serSel[i]),
      .serClkVal(serVal[i]),
      .perSel(perSel[i]),
      .perOe(perOe[i]),
      .perVal(perVal[i]),
      .portDir(dir_reg[i]),
      .portVal(latch_reg[i]),
      .pinOe(cellOe[i]),
      .pinVal(cellVal[i])
    );
  end

  // Registered outputs; one cycle behind decode keeps every output on a flop
  always_comb begin
    oe_next = cellOe;
    out_next = cellVal;
    slv_next.slaveWriteN = pinIn[2];
    slv_next.slaveReadN = pinIn[3];
    slv_next.slaveAddrLo = pinIn[4];
    slv_next.slaveAddrHi = pinIn[5];
    slv_next.chipSelectN = ctrl_reg[BGP_CSSEL_BIT] ? pinIn[6] : other_port_pin_seven;
    ser_next = pinIn[1:0];
    flags_next = {extOn, slaveOn, ctrl_reg[BGP_FETCH_BIT], 1'b0};
  end

  // Single register stage for all state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dir_reg <= BGP_DIR_RESET;
      hold_reg <= BGP_LATCH_RESET;
      holdPend_reg <= 1'b0;
      latch_reg <= BGP_LATCH_RESET;
      ctrl_reg <= BGP_CTRL_RESET;
      rdata_reg <= 8'h00;
      oe_reg <= BGP_DIR_RESET;
      out_reg <= BGP_LATCH_RESET;
      slv_reg <= '1;
      ser_reg <= 2'h0;
      flags_reg <= 4'h0;
    end else if (clkEn) begin
      dir_reg <= dir_next;
      hold_reg <= hold_next;
      holdPend_reg <= holdPend_next;
      latch_reg <= latch_next;
      ctrl_reg <= ctrl_next;
      rdata_reg <= rdata_next;
      oe_reg <= oe_next;
      out_reg <= out_next;
      slv_reg <= slv_next;
      ser_reg <= ser_next;
      flags_reg <= flags_next;
    end
  end

  // Interrupt level only passes through to the slave port; no port interrupt
  assign rdata = rdata_reg;
  assign pinOut = out_reg;
  assign pinOe = oe_reg;
  assign slaveSig = slv_reg;
  assign serClkIn = ser_reg;
  assign extIoEnable = flags_reg[3];
  assign slaveEnable = flags_reg[2];
  assign fetchIgnore = flags_reg[1];
  assign slaveIrqLevel = ctrl_reg[BGP_ILVL_HI:BGP_ILVL_LO];

  // ************************************************************
  // Checks
  // ************************************************************
  sequence dataWrite_q;
    clkEn && bus.wr && bus.addr == BGP_ADDR_DATA;
  endsequence

  sequence latchLoad_q;
    clkEn [*2];
  endsequence

  latch_after_write_a: assert property (@(posedge core_clk) disable iff (rst)
    dataWrite_q ##1 latchLoad_q |-> latch_reg == $past(bus.wdata, 2))
    else $error("latch did not take buffered write");
  reset_direction_a: assert property (@(posedge core_clk)
    rst |=> dir_reg == 8'hc0 && latch_reg == 8'h00)
    else $error("reset direction wrong");
  dir_write_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && bus.wr && bus.addr == BGP_ADDR_DIRECTION |=> dir_reg == $past(bus.wdata))
    else $error("direction not written");
  data_read_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && bus.rd && bus.addr == BGP_ADDR_DATA |=> rdata == $past(pinIn))
    else $error("data read not pin level");
  boot_read_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && bus.rd && bus.addr == BGP_ADDR_CONTROL |=> rdata[6:5] == $past(boot_mode_pins))
    else $error("boot bits not reported");
  ext_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && extOn && serClkOutSel == 2'h0 |=>
      pinOe == (8'hfc | {6'h00, $past(dir_reg[1:0])})
      && pinOut[7:2] == $past(extIoAddr))
    else $error("external address not on pins");
  serial_clock_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && serClkOutSel[0] |=> pinOe[0] && pinOut[0] == $past(serClkOut[0]))
    else $error("serial clock not overriding");
  slave_attn_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && slaveOn && !extOn |=> pinOe[7] && pinOut[7] == $past(attention_out_n)
      && !pinOe[5] && !pinOe[2])
    else $error("slave pins wrong");
  cs_select_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && ctrl_reg[4] |=> slaveSig.chipSelectN == $past(pinIn[6]))
    else $error("chip select source wrong");
  free_pin_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !extOn && !slaveOn && serClkOutSel == 2'h0 |=> pinOe == $past(dir_reg))
    else $error("free pin not under direction");

  // ************************************************************
  // Further checks on registers and pins
  // ************************************************************
  sequence ctrlWrite_q;
    clkEn && bus.wr && bus.addr == BGP_ADDR_CONTROL;
  endsequence

  sequence dirRead_q;
    clkEn && bus.rd && bus.addr == BGP_ADDR_DIRECTION;
  endsequence

  // Control write drops the boot bits; the low field goes straight out
  ctrl_write_a: assert property (@(posedge core_clk) disable iff (rst)
    ctrlWrite_q |=> ctrl_reg == ($past(bus.wdata) & BGP_CTRL_WMASK))
    else $error("control write not masked");
  irq_level_a: assert property (@(posedge core_clk) disable iff (rst)
    ctrlWrite_q |=> slaveIrqLevel == $past(bus.wdata[1:0]))
    else $error("interrupt level not written");
  dir_read_a: assert property (@(posedge core_clk) disable iff (rst)
    dirRead_q |=> rdata == 8'h00)
    else $error("direction read not zero");
  hold_load_a: assert property (@(posedge core_clk) disable iff (rst)
    dataWrite_q |=> hold_reg == $past(bus.wdata))
    else $error("holding buffer not loaded");

  // Status flags trail the decode by one edge
  fetch_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn |=> fetchIgnore == $past(ctrl_reg[BGP_FETCH_BIT]))
    else $error("fetch flag wrong");
  mode_flags_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn |=> slaveEnable == $past(slaveOn) && extIoEnable == $past(extOn))
    else $error("mode flags wrong");

  // Pin side: first serial clock, slave strobes, other chip select, free pins
  serial_first_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && serClkOutSel[1] |=> pinOe[1] && pinOut[1] == $past(serClkOut[1]))
    else $error("first serial clock not overriding");
  slave_inputs_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && slaveOn |=> slaveSig.slaveReadN == $past(pinIn[3])
      && slaveSig.slaveWriteN == $past(pinIn[2]) && slaveSig.slaveAddrHi == $past(pinIn[5]))
    else $error("slave strobes not sampled");
  cs_other_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !ctrl_reg[BGP_CSSEL_BIT]
      |=> slaveSig.chipSelectN == $past(other_port_pin_seven))
    else $error("other chip select not taken");
  input_pin_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !extOn && !slaveOn && serClkOutSel == 2'h0
      |=> (pinOut & pinOe) == ($past(latch_reg) & $past(dir_reg)))
    else $error("free pin drives wrong level");

  // A low enable must hold every register, outputs included
  freeze_a: assert property (@(posedge core_clk) disable iff (rst)
    !clkEn |=> $stable(dir_reg) && $stable(latch_reg) && $stable(ctrl_reg)
      && $stable(pinOe))
    else $error("state moved while enable low");
  latch_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !holdPend_reg |=> $stable(latch_reg))
    else $error("latch moved without buffered write");
  rdata_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    clkEn && !bus.rd |=> $stable(rdata))
    else $error("read data moved without read");
  reset_pins_a: assert property (@(posedge core_clk)
    rst |=> pinOe == BGP_DIR_RESET && pinOut == BGP_LATCH_RESET)
    else $error("reset pin state wrong");
endmodule

// *** verification/bgp_pin_partner.sv ***
// Model of the circuitry on the eight port pins, with weak pull-ups
module bgp_pin_partner
  import bgp_pkg::*;
(
  input wire logic [7:0] pinOut, // Device drive levels
  input wire logic [7:0] pinOe, // Device enables, high drives
  input wire logic [7:0] extEn, // Far side drives the pin
  input wire logic [7:0] extVal, // Far side levels
  output logic [7:0] pinLvl // Resolved wire levels
);
  timeunit 1ns;
  timeprecision 1ns;
  // Device wins where it drives; a released line floats up to its pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinLvl[i] = pinOe[i] ? pinOut[i] : (extEn[i] ? extVal[i] : 1'b1);
    end
  end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the byte-wide port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bgp_pkg::*;
  // ************************************************************
  // Stimulus, design and pin model
  // ************************************************************
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  bgp_bus_s bus = '0;
  logic [1:0] bootPins = 2'h2;
  logic parBoot = 1'b0;
  logic attnN = 1'b0;
  logic csAlt = 1'b0;
  logic [5:0] extAddr = 6'h2b;
  logic [1:0] sclkSel = 2'h0;
  logic [1:0] sclk = 2'h2;
  logic [7:0] extEn = 8'h3f;
  logic [7:0] extVal = 8'h00;
  logic [7:0] rdata, pinOut, pinOe, pinLvl;
  bgp_slave_s slaveSig;
  logic [1:0] serClkIn, slaveIrqLevel;
  logic extIoEnable, slaveEnable, fetchIgnore;
  int checks = 0;
  int mismatches = 0;
  // Rows: direction, data, far-side level
  logic [23:0] rows [3] = '{24'hff5a00, 24'h00a53c, 24'h0fc396};

  always #50 core_clk = ~core_clk;

  bgp_port i_bgp_port (.core_clk(core_clk), .rst(rst), .clkEn(clkEn), .bus(bus),
    .rdata(rdata), .pinIn(pinLvl), .pinOut(pinOut), .pinOe(pinOe),
    .boot_mode_pins(bootPins), .parallelBoot(parBoot), .attention_out_n(attnN),
    .other_port_pin_seven(csAlt), .extIoAddr(extAddr), .serClkOutSel(sclkSel),
    .serClkOut(sclk), .slaveSig(slaveSig), .serClkIn(serClkIn),
    .extIoEnable(extIoEnable), .slaveEnable(slaveEnable),
    .slaveIrqLevel(slaveIrqLevel), .fetchIgnore(fetchIgnore));

  bgp_pin_partner i_bgp_pin_partner (.pinOut(pinOut), .pinOe(pinOe), .extEn(extEn),
    .extVal(extVal), .pinLvl(pinLvl));

  // ************************************************************
  // Tasks
  // ************************************************************
  // One-cycle request; read data is taken after the answering edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge core_clk);
    bus = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(negedge core_clk);
    bus = '0;
    q = rdata;
  endtask

  // Buffer, latch and pin register all land within three edges
  task automatic settle();
    repeat (3) @(negedge core_clk);
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  // Hang guard: a stuck run counts as a mismatch
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] q, dir, dat, ext;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    chk(pinOe, 8'hc0);
    chk(pinOut, 8'h00);
    // Direction is set before data, as software must do
    foreach (rows[r]) begin
      {dir, dat, ext} = rows[r];
      extEn = ~dir;
      extVal = ext;
      acc(1'b1, BGP_ADDR_DIRECTION, dir, q);
      acc(1'b1, BGP_ADDR_DATA, dat, q);
      settle();
      chk(pinOe, dir);
      chk(pinOut & dir, dat & dir);
      acc(1'b0, BGP_ADDR_DATA, 8'h00, q);
      chk(q, (dat & dir) | (ext & ~dir));
    end
    // Bits written while inputs appear once the pins turn to outputs
    extEn = 8'h00;
    acc(1'b1, BGP_ADDR_DIRECTION, 8'hff, q);
    settle();
    acc(1'b0, BGP_ADDR_DATA, 8'h00, q);
    chk(q, 8'hc3);
    // Every port mode, with the boot bits written high to be dropped
    acc(1'b1, BGP_ADDR_DIRECTION, 8'h3c, q);
    extVal = 8'h5a;
    for (int m = 0; m < 4; m++) begin
      extEn = (m == 3) ? 8'h03 : (m == 2) ? 8'h7f : 8'hc3;
      acc(1'b1, BGP_ADDR_CONTROL, {4'hf, m[1:0], m[1:0]}, q);
      settle();
      chk(slaveEnable, m == 2);
      chk(extIoEnable, m == 3);
      chk(slaveIrqLevel, m[1:0]);
      chk(fetchIgnore, 1'b1);
      acc(1'b0, BGP_ADDR_CONTROL, 8'h00, q);
      chk(q[6:5], bootPins);
      if (m == 3) chk(pinOe, 8'hfc);
      if (m == 3) chk(pinOut[7:2], extAddr);
      if (m == 2) chk(pinOe, 8'h80);
      if (m == 2) chk(pinOut[7], attnN);
      if (m == 2) chk(slaveSig, 5'h13);
      if (m < 2) chk(pinOe, 8'h3c);
    end
    // Chip select from the other port; fetch follows the boot pins
    extEn = 8'h7f;
    acc(1'b1, BGP_ADDR_CONTROL, 8'h08, q);
    settle();
    chk(slaveSig.chipSelectN, csAlt);
    chk(fetchIgnore, 1'b0);
    acc(1'b1, BGP_ADDR_CONTROL, 8'h00, q);
    parBoot = 1'b1;
    settle();
    chk(slaveEnable, 1'b1);
    chk(pinOe, 8'h80);
    parBoot = 1'b0;
    sclkSel = 2'h3;
    settle();
    chk(pinOe[1:0], 2'h3);
    chk(pinOut[1:0], sclk);
    chk(serClkIn, sclk);
    acc(1'b0, BGP_ADDR_DIRECTION, 8'h00, q);
    chk(q, 8'h00);
    acc(1'b0, 8'h55, 8'h00, q);
    chk(q, 8'h00);
    // A low enable freezes the port, so a write in that time is lost
    clkEn = 1'b0;
    acc(1'b1, BGP_ADDR_DIRECTION, 8'h00, q);
    clkEn = 1'b1;
    settle();
    chk(pinOe, 8'h3f);
    // Second reset in mid-run restores the start-up pin state
    sclkSel = 2'h0;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    chk(pinOe, 8'hc0);
    chk(pinOut, 8'h00);
    chk(rdata, 8'h00);
    settle();
    chk(pinOe, 8'hc0);
    acc(1'b0, BGP_ADDR_CONTROL, 8'h00, q);
    chk(q, {1'b0, bootPins, 5'h00});
    tally_and_finish();
  end
endmodule
